// ### design/usp_pkg.sv
// Behaviour
// - transmitter and receiver run independently and concurrently in the uart modes
// - uart modes: receiver shifts a new character while the previous one waits unread
// - a newly completed character overwrites an unread earlier one
// - buffer address: write loads transmitter, read returns separate receive register
// - control bits 7:6 select shift, 8-bit uart, fixed 9-bit, variable 9-bit
// - shift-register mode bit clock is core clock divided by two
// - fixed 9-bit mode bit rate is core clock over 32 or 16
// - 8-bit uart with filter set: no receive-full flag on bad stop bit
// - 9-bit modes with filter set: no receive-full flag when ninth bit is 0
// - receive enable set allows reception, clear disables it
// - 9-bit modes send the transmit ninth-bit field as ninth bit
// - receive ninth-bit field takes ninth bit, or stop bit in 8-bit uart
// - transmit-done set after 8th bit in shift mode, at stop start otherwise
// - receive-full set after 8th bit in shift mode, mid stop bit otherwise
// - shift mode: data both ways on receive pin, clock out on transmit pin
// - shift mode: buffer write shifts out eight bits, lsb first
// - shift mode: receive starts when enable is 1 and receive-full is 0
// - 8-bit uart frame: start 0, eight data lsb first, stop 1
// - 9-bit frame: start, eight data, ninth bit, stop: eleven bits
// - fixed 9-bit mode: doubler set gives divide by 16, clear by 32
// - uart modes: reception begins on a start bit while enable is set
package usp_pkg;

  localparam logic [7:0] CTRL_ADDR     = 8'h98;
  localparam logic [7:0] BUF_ADDR      = 8'h99;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;

  localparam logic [2:0] SHIFT_LAST  = 3'h7;
  localparam logic [3:0] TX_BITS_8   = 4'ha;
  localparam logic [3:0] TX_BITS_9   = 4'hb;
  localparam logic [3:0] RX_STOP_8   = 4'h9;
  localparam logic [3:0] RX_STOP_9   = 4'ha;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_FIX9  = 2'b10,
    MODE_VAR9  = 2'b11
  } usp_mode_t;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic address_filter_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_full_flag;
  } usp_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usp_sfr_req_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       mid;
    logic       fin;
  } usp_timer_t;

  typedef struct packed {
    usp_ctrl_t   ctrl;
    logic [7:0]  rx_buf;
    logic [7:0]  rdata;
    logic        div;
    logic        rxd_s1;
    logic        rxd_s2;
    logic        rxd_prev;
    logic        sh_busy;
    logic        sh_tx;
    logic        sh_ph;
    logic [2:0]  sh_cnt;
    logic [7:0]  sh_reg;
    logic        tx_busy;
    logic [10:0] tx_sh;
    logic [3:0]  tx_left;
    logic        txd;
    logic        rx_busy;
    logic [3:0]  rx_cnt;
    logic [8:0]  rx_sh;
    logic        rxd_o;
    logic        rxd_oe_b;
  } usp_state_t;

  localparam usp_state_t STATE_RST = '{
    ctrl:     usp_ctrl_t'(CTRL_RST),
    rxd_s1:   1'b1,
    rxd_s2:   1'b1,
    rxd_prev: 1'b1,
    txd:      1'b1,
    rxd_o:    1'b1,
    rxd_oe_b: 1'b1,
    default:  '0
  };

endpackage : usp_pkg

// ### design/usp_bit_timer.sv
`timescale 1ns/1ns
module usp_bit_timer (
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_restart,
  input  wire logic i_tick,
  output logic      o_mid,
  output logic      o_end
);

  usp_pkg::usp_timer_t q;
  usp_pkg::usp_timer_t d;

  // sixteen oversample ticks per bit
  always_comb begin
    d     = q;
    d.mid = 1'b0;
    d.fin = 1'b0;
    if (i_restart) begin
      d.cnt = 4'h0;
    end else if (i_tick) begin
      d.mid = (q.cnt == usp_pkg::TICK_MID);
      d.fin = (q.cnt == usp_pkg::TICK_LAST);
      d.cnt = 4'(q.cnt + 4'h1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_mid = q.mid;
  assign o_end = q.fin;

endmodule : usp_bit_timer

// ### design/usp_serial_port.sv
`timescale 1ns/1ns
module usp_serial_port (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_b,
  input  wire usp_pkg::usp_sfr_req_t i_sfr,
  input  wire logic                  i_baud_doubler,
  input  wire logic                  i_baud_tick16,
  input  wire logic                  i_rxd,
  output logic [7:0]                 o_sfr_rdata,
  output logic                       o_rxd,
  output logic                       o_rxd_oe_b,
  output logic                       o_txd
);

  usp_pkg::usp_state_t q;
  usp_pkg::usp_state_t d;

  logic              wr_ctrl;
  logic              wr_buf;
  usp_pkg::usp_mode_t mode;
  logic              is_shift;
  logic              nine_bit;
  logic              tick16;
  logic              tx_mid_unused;
  logic              tx_end;
  logic              rx_mid;
  logic              rx_end_unused;
  logic              tx_load;
  logic              tx_stop_next;
  logic              rx_start;
  logic              rx_at_stop;
  logic              rx_ninth;
  logic [7:0]        rx_data;
  logic              rx_accept;
  logic              sh_start_tx;
  logic              sh_start_rx;
  logic              sh_done;
  logic [7:0]        sh_next;
  logic              ti_set;
  logic              ri_set;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  assign wr_ctrl  = i_sfr.wr && addr_hit(i_sfr.addr, usp_pkg::CTRL_ADDR);
  assign wr_buf   = i_sfr.wr && addr_hit(i_sfr.addr, usp_pkg::BUF_ADDR);
  assign mode     = usp_pkg::usp_mode_t'({q.ctrl.mode_select_high,
                                          q.ctrl.mode_select_low});
  assign is_shift = (mode == usp_pkg::MODE_SHIFT);
  assign nine_bit = (mode == usp_pkg::MODE_FIX9) || (mode == usp_pkg::MODE_VAR9);

  // fixed 9-bit mode: tick every 2 clocks (/32) or every clock (/16)
  assign tick16 = (mode == usp_pkg::MODE_FIX9) ? (i_baud_doubler || q.div)
                                               : i_baud_tick16;

  // separate bit timers keep the two directions apart
  usp_bit_timer u_tx_timer (
    .i_mclk    (i_mclk),
    .i_rst_b   (i_rst_b),
    .i_restart (tx_load),
    .i_tick    (tick16),
    .o_mid     (tx_mid_unused),
    .o_end     (tx_end)
  );

  usp_bit_timer u_rx_timer (
    .i_mclk    (i_mclk),
    .i_rst_b   (i_rst_b),
    .i_restart (rx_start),
    .i_tick    (tick16),
    .o_mid     (rx_mid),
    .o_end     (rx_end_unused)
  );

  // uart transmitter
  assign tx_load      = wr_buf && !is_shift && !q.tx_busy;
  assign tx_stop_next = q.tx_busy && tx_end && (q.tx_left == 4'h2);

  // uart receiver
  assign rx_start   = !q.rx_busy && q.rxd_prev && !q.rxd_s2 &&
                      q.ctrl.rx_enable && !is_shift;
  assign rx_at_stop = q.rx_busy && rx_mid && q.ctrl.rx_enable && !is_shift &&
                      (q.rx_cnt == (nine_bit ? usp_pkg::RX_STOP_9 : usp_pkg::RX_STOP_8));
  assign rx_ninth   = nine_bit ? q.rx_sh[8] : q.rxd_s2;
  assign rx_data    = nine_bit ? q.rx_sh[7:0] : q.rx_sh[8:1];
  // filter: 8-bit needs a good stop, 9-bit needs ninth bit set
  assign rx_accept  = rx_at_stop &&
                      (!q.ctrl.address_filter_enable || rx_ninth);

  // shift-register mode engine
  assign sh_start_tx = is_shift && !q.sh_busy && wr_buf;
  assign sh_start_rx = is_shift && !q.sh_busy && !wr_buf &&
                       q.ctrl.rx_enable && !q.ctrl.rx_full_flag;
  assign sh_done     = q.sh_busy && q.sh_ph && (q.sh_cnt == usp_pkg::SHIFT_LAST);
  assign sh_next     = {q.sh_tx ? 1'b1 : q.rxd_s2, q.sh_reg[7:1]};

  assign ti_set = (sh_done && q.sh_tx) || tx_stop_next;
  assign ri_set = (sh_done && !q.sh_tx) || rx_accept;

  always_comb begin
    d          = q;
    d.div      = ~q.div;
    d.rxd_s1   = i_rxd;
    d.rxd_s2   = q.rxd_s1;
    d.rxd_prev = q.rxd_s2;

    if (wr_ctrl) begin
      d.ctrl = usp_pkg::usp_ctrl_t'(i_sfr.wdata);
    end
    // hardware set wins over a software clear in the same cycle
    if (ti_set) begin
      d.ctrl.tx_done_flag = 1'b1;
    end
    if (ri_set) begin
      d.ctrl.rx_full_flag = 1'b1;
    end

    if (i_sfr.rd) begin
      if (addr_hit(i_sfr.addr, usp_pkg::CTRL_ADDR)) begin
        d.rdata = q.ctrl;
      end else if (addr_hit(i_sfr.addr, usp_pkg::BUF_ADDR)) begin
        d.rdata = q.rx_buf;
      end else begin
        d.rdata = usp_pkg::UNMAPPED_READ;
      end
    end

    // shift-register mode: clock on txd, data both ways on rxd
    if (sh_start_tx || sh_start_rx) begin
      d.sh_busy  = 1'b1;
      d.sh_tx    = sh_start_tx;
      d.sh_ph    = 1'b0;
      d.sh_cnt   = 3'h0;
      d.sh_reg   = sh_start_tx ? i_sfr.wdata : q.sh_reg;
      d.txd      = 1'b0;
      d.rxd_o    = sh_start_tx ? i_sfr.wdata[0] : 1'b1;
      d.rxd_oe_b = !sh_start_tx;
    end else if (q.sh_busy) begin
      if (!q.sh_ph) begin
        d.sh_ph = 1'b1;
        d.txd   = 1'b1;
      end else if (sh_done) begin
        d.sh_busy  = 1'b0;
        d.rxd_o    = 1'b1;
        d.rxd_oe_b = 1'b1;
        if (!q.sh_tx) begin
          d.rx_buf = sh_next;
        end
      end else begin
        d.sh_ph  = 1'b0;
        d.sh_cnt = 3'(q.sh_cnt + 3'h1);
        d.sh_reg = sh_next;
        d.txd    = 1'b0;
        d.rxd_o  = sh_next[0];
      end
    end

    // uart transmit: start, data lsb first, [ninth], stop
    if (tx_load) begin
      d.tx_busy = 1'b1;
      d.tx_sh   = {1'b1, nine_bit ? q.ctrl.tx_ninth_bit : 1'b1,
                   i_sfr.wdata, 1'b0};
      d.tx_left = nine_bit ? usp_pkg::TX_BITS_9 : usp_pkg::TX_BITS_8;
      d.txd     = 1'b0;
    end else if (q.tx_busy && tx_end) begin
      if (q.tx_left == 4'h1) begin
        d.tx_busy = 1'b0;
        d.txd     = 1'b1;
      end else begin
        d.tx_sh   = {1'b1, q.tx_sh[10:1]};
        d.tx_left = 4'(q.tx_left - 4'h1);
        d.txd     = q.tx_sh[1];
      end
    end

    // uart receive, sampled mid bit
    if (rx_start) begin
      d.rx_busy = 1'b1;
      d.rx_cnt  = 4'h0;
    end else if (q.rx_busy) begin
      if (!q.ctrl.rx_enable || is_shift) begin
        d.rx_busy = 1'b0;
      end else if (rx_mid) begin
        if (q.rx_cnt == 4'h0 && q.rxd_s2) begin
          d.rx_busy = 1'b0;
        end else if (rx_at_stop) begin
          d.rx_busy = 1'b0;
        end else begin
          d.rx_sh  = {q.rxd_s2, q.rx_sh[8:1]};
          d.rx_cnt = 4'(q.rx_cnt + 4'h1);
        end
      end
    end
    if (rx_accept) begin
      d.rx_buf            = rx_data;
      d.ctrl.rx_ninth_bit = rx_ninth;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= usp_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign o_sfr_rdata = q.rdata;
  assign o_rxd       = q.rxd_o;
  assign o_rxd_oe_b  = q.rxd_oe_b;
  assign o_txd       = q.txd;

  property p_ti_sticky;
    @(posedge i_mclk) disable iff (!i_rst_b)
      $past(q.ctrl.tx_done_flag) && !$past(wr_ctrl) |-> q.ctrl.tx_done_flag;
  endproperty
  a_ti_sticky: assert property (p_ti_sticky) else $error("done flag dropped");

  property p_ri_sticky;
    @(posedge i_mclk) disable iff (!i_rst_b)
      q.ctrl.rx_full_flag && !wr_ctrl |=> q.ctrl.rx_full_flag;
  endproperty
  a_ri_sticky: assert property (p_ri_sticky) else $error("full flag dropped");

  property p_shift_clock;
    @(posedge i_mclk) disable iff (!i_rst_b)
      q.sh_busy && $past(q.sh_busy) |-> q.txd != $past(q.txd);
  endproperty
  a_shift_clock: assert property (p_shift_clock) else $error("shift clock not /2");

  property p_shift_len;
    @(posedge i_mclk) disable iff (!i_rst_b)
      $rose(q.sh_busy) |-> q.sh_busy [*8] ##1 q.sh_busy [*8] ##1 !q.sh_busy;
  endproperty
  a_shift_len: assert property (p_shift_len) else $error("shift transfer length wrong");

  property p_shift_rx_gate;
    @(posedge i_mclk) disable iff (!i_rst_b)
      $rose(q.sh_busy) && !q.sh_tx |-> $past(q.ctrl.rx_enable) && !$past(q.ctrl.rx_full_flag);
  endproperty
  a_shift_rx_gate: assert property (p_shift_rx_gate) else $error("shift rx start gated wrong");

  property p_ren_off;
    @(posedge i_mclk) disable iff (!i_rst_b)
      !q.ctrl.rx_enable ##1 !q.ctrl.rx_enable |-> !q.rx_busy;
  endproperty
  a_ren_off: assert property (p_ren_off) else $error("receive while disabled");

  property p_tx_start;
    @(posedge i_mclk) disable iff (!i_rst_b)
      tx_load |=> !q.txd && q.tx_busy && q.tx_sh[0] == 1'b0;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");

  property p_overwrite;
    @(posedge i_mclk) disable iff (!i_rst_b)
      rx_accept |=> q.rx_buf == $past(rx_data) && q.ctrl.rx_full_flag;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("received byte not stored");

  property p_filter;
    @(posedge i_mclk) disable iff (!i_rst_b)
      rx_at_stop && q.ctrl.address_filter_enable && !rx_ninth && !q.ctrl.rx_full_flag
      && !wr_ctrl |=> !q.ctrl.rx_full_flag;
  endproperty
  a_filter: assert property (p_filter) else $error("filtered frame set full flag");

  property p_ti_at_stop;
    @(posedge i_mclk) disable iff (!i_rst_b)
      tx_stop_next |=> q.txd && q.ctrl.tx_done_flag && q.tx_left == 4'h1;
  endproperty
  a_ti_at_stop: assert property (p_ti_at_stop) else $error("done flag not at stop");

  property p_rd_ctrl;
    @(posedge i_mclk) disable iff (!i_rst_b)
      i_sfr.rd && (i_sfr.addr == usp_pkg::CTRL_ADDR) |=> q.rdata == $past(q.ctrl);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_rd_buf;
    @(posedge i_mclk) disable iff (!i_rst_b)
      i_sfr.rd && (i_sfr.addr == usp_pkg::BUF_ADDR) |=> q.rdata == $past(q.rx_buf);
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("buffer read not receive reg");

  property p_shift_oe;
    @(posedge i_mclk) disable iff (!i_rst_b)
      q.sh_busy && q.sh_tx |-> !q.rxd_oe_b;
  endproperty
  a_shift_oe: assert property (p_shift_oe) else $error("shift tx not driving data pin");

  property p_oe_idle;
    @(posedge i_mclk) disable iff (!i_rst_b)
      !q.sh_busy |-> q.rxd_oe_b;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data pin driven while idle");

  property p_txd_idle;
    @(posedge i_mclk) disable iff (!i_rst_b)
      !q.sh_busy && !q.tx_busy |-> q.txd;
  endproperty
  a_txd_idle: assert property (p_txd_idle) else $error("transmit pin not idle high");

  property p_tx_ninth;
    @(posedge i_mclk) disable iff (!i_rst_b)
      tx_load && nine_bit |=> q.tx_sh[9] == $past(q.ctrl.tx_ninth_bit);
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("ninth bit not loaded");

  property p_tx_len;
    @(posedge i_mclk) disable iff (!i_rst_b)
      tx_load |=> q.tx_left == ($past(nine_bit) ? usp_pkg::TX_BITS_9 : usp_pkg::TX_BITS_8);
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("frame length wrong");

  property p_stop_to_rb8;
    @(posedge i_mclk) disable iff (!i_rst_b)
      rx_accept && (mode == usp_pkg::MODE_UART8) |=> q.ctrl.rx_ninth_bit == $past(q.rxd_s2);
  endproperty
  a_stop_to_rb8: assert property (p_stop_to_rb8) else $error("stop bit not captured");

  property p_filter8;
    @(posedge i_mclk) disable iff (!i_rst_b)
      rx_at_stop && (mode == usp_pkg::MODE_UART8) && q.ctrl.address_filter_enable &&
      !q.rxd_s2 && !q.ctrl.rx_full_flag && !wr_ctrl |=> !q.ctrl.rx_full_flag;
  endproperty
  a_filter8: assert property (p_filter8) else $error("bad stop set full flag");

  property p_shift_done_flags;
    @(posedge i_mclk) disable iff (!i_rst_b)
      sh_done |=> ($past(q.sh_tx) ? q.ctrl.tx_done_flag : q.ctrl.rx_full_flag);
  endproperty
  a_shift_done_flags: assert property (p_shift_done_flags) else $error("shift flag missing");

endmodule : usp_serial_port

// ### dv/usp_remote_model.sv
`timescale 1ns/1ns
module usp_remote_model (
  input  wire logic       i_mclk,
  input  wire logic       i_txd,
  input  wire logic       i_rxd_o,
  input  wire logic       i_oe_b,
  input  wire logic [4:0] i_bits,
  input  wire logic [5:0] i_blen,
  output logic            o_line
);
  logic [10:0] frame;
  logic [7:0]  sh;
  int          n = 0;
  event        got;

  initial o_line = 1'b1;

  // uart frames from the device, sampled mid-cell
  always begin
    @(negedge i_txd);
    if (i_bits != 5'h00) begin
      frame = 11'h7ff;
      repeat (i_blen / 2) @(posedge i_mclk);
      for (int i = 0; i < i_bits; i++) begin
        #1 frame[i] = i_txd;
        if (i < i_bits - 1) repeat (i_blen) @(posedge i_mclk);
      end
      -> got;
    end
  end

  // shift mode peripheral: data valid on clock rise
  always @(posedge i_txd) begin
    if (!i_oe_b && i_bits == 5'h00) begin
      sh = {i_rxd_o, sh[7:1]};
      n++;
      if (n == 8) begin
        frame = {3'h7, sh};
        n = 0;
        -> got;
      end
    end
  end

  // line idles high between frames
  task automatic send(input logic [10:0] f, input logic [4:0] nb, input logic [5:0] bl);
    for (int i = 0; i < nb; i++) begin
      @(negedge i_mclk) o_line = f[i];
      repeat (bl - 1) @(negedge i_mclk);
    end
    @(negedge i_mclk) o_line = 1'b1;
  endtask : send
endmodule : usp_remote_model

// ### dv/usp_serial_port_tb.sv
`timescale 1ns/1ns
module usp_serial_port_tb;
  logic                  i_mclk         = 1'b0;
  logic                  i_rst_b        = 1'b0;
  usp_pkg::usp_sfr_req_t i_sfr          = '0;
  logic                  i_baud_doubler = 1'b0;
  logic                  i_baud_tick16  = 1'b1;
  logic [7:0]            o_sfr_rdata;
  logic                  o_rxd;
  logic                  o_rxd_oe_b;
  logic                  o_txd;
  logic                  m_line;
  wire                   rxd_pin = o_rxd_oe_b ? m_line : o_rxd;
  logic [4:0]            bits = 5'h00;
  logic [5:0]            blen = 6'h10;
  logic                  rd_seen = 1'b0;
  logic [7:0]            rd_q[$];
  logic [7:0]            mk_q[$];
  logic [10:0]           fr_q[$];
  int                    bad_count = 0;
  int                    checks_done = 0;
  int                    seed = 86632;

  always #50 i_mclk = ~i_mclk;

  usp_serial_port i_dut (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .i_sfr         (i_sfr),
    .i_baud_doubler(i_baud_doubler),
    .i_baud_tick16 (i_baud_tick16),
    .i_rxd         (rxd_pin),
    .o_sfr_rdata   (o_sfr_rdata),
    .o_rxd         (o_rxd),
    .o_rxd_oe_b    (o_rxd_oe_b),
    .o_txd         (o_txd)
  );

  usp_remote_model i_remote (
    .i_mclk (i_mclk),
    .i_txd  (o_txd),
    .i_rxd_o(o_rxd),
    .i_oe_b (o_rxd_oe_b),
    .i_bits (bits),
    .i_blen (blen),
    .o_line (m_line)
  );

  task automatic cmp(input string what, input logic [10:0] e, input logic [10:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic chk_rd(input logic [7:0] e, input logic [7:0] mk);
    cmp("rdata", {3'h0, e & mk}, {3'h0, o_sfr_rdata & mk});
  endtask : chk_rd

  task automatic chk_fr(input logic [10:0] e);
    cmp("line frame", e, i_remote.frame);
  endtask : chk_fr

  always @(posedge i_mclk) rd_seen <= i_sfr.rd;
  always @(negedge i_mclk) if (rd_seen) chk_rd(rd_q.pop_front(), mk_q.pop_front());
  always @(i_remote.got) chk_fr(fr_q.pop_front());

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk) i_sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge i_mclk) i_sfr.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    rd_q.push_back(e);
    mk_q.push_back(mk);
    @(negedge i_mclk) i_sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge i_mclk) i_sfr.rd = 1'b0;
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge i_mclk);
    bad_count++;
    end_sim();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] c;
    logic       tb;
    logic       nb;
    i_baud_doubler = 1'($random(seed));
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk) i_rst_b = 1'b1;
    rd(8'h98, 8'h00, 8'hff);
    rd(8'h42, 8'h00, 8'hff);
    $display("test reset done");
    d = 8'($random(seed));
    fr_q.push_back({3'h7, d});
    wr(8'h99, d);
    repeat (20) @(negedge i_mclk);
    rd(8'h98, 8'h02, 8'hff);
    for (int v = 0; v < 2; v++) begin
      i_remote.o_line = v[0];
      wr(8'h98, 8'h10);
      repeat (24) @(negedge i_mclk);
      rd(8'h98, 8'h11, 8'hff);
      rd(8'h99, {8{v[0]}}, 8'hff);
    end
    i_remote.o_line = 1'b1;
    $display("test shift mode done");
    for (int m = 1; m < 4; m++) begin
      blen = (m == 2 && !i_baud_doubler) ? 6'h20 : 6'h10;
      bits = (m == 1) ? 5'h0a : 5'h0b;
      for (int p = 0; p < 3; p++) begin
        d = 8'($random(seed));
        r = 8'($random(seed));
        tb = 1'($random(seed));
        nb = (p == 1) ? 1'b0 : ((m == 1) ? 1'b1 : 1'($random(seed)));
        c = {m[1:0], p == 1, p != 2, tb, 3'h0};
        wr(8'h98, c);
        fr_q.push_back({1'b1, (m == 1) | tb, d, 1'b0});
        wr(8'h99, d);
        i_remote.send({1'b1, nb, r, 1'b0}, bits, blen);
        i_remote.send({1'b1, nb, ~r, 1'b0}, bits, blen);
        repeat (blen) @(negedge i_mclk);
        rd(8'h98, c | {5'h0, nb, 1'b1, p == 0}, (p == 0) ? 8'hff : 8'hfb);
        if (p == 0) rd(8'h99, ~r, 8'hff);
      end
      $display("test uart mode %0d done", m);
    end
    repeat (4) @(negedge i_mclk);
    end_sim();
  end
endmodule : usp_serial_port_tb
